// *** core/flash_pin_consts.svh ***
// constants for the serial flash pin logic
`ifndef FLASH_PIN_CONSTS_SVH
`define FLASH_PIN_CONSTS_SVH
// ==========================================================
// widths, counts and reset values
`define FP_BYTE_BITS 4'h8
`define FP_CNT_RST 4'h0
`define FP_W_SINGLE 4'h1
`define FP_W_DUAL 4'h2
`define FP_W_QUAD 4'h4
`define FP_LANES_OFF 4'h0
`define FP_OE_SINGLE 4'h2
`define FP_OE_DUAL 4'h3
`define FP_OE_QUAD 4'hf
// sync chains wake up deselected, clock low, upper lanes at their pull-up level
`define FP_SYNC_RST 6'h32
`define FP_BYTE_RST 8'h00
`define FP_WP_RST 1'h0
`endif

// *** core/flash_pin_pkg.sv ***
// types shared by the serial flash pin logic
package flash_pin_pkg;
  // ==========================================================
  // lane usage of the command phase under way
  typedef enum logic [2:0] {
    MODE_SINGLE_IN,
    MODE_SINGLE_OUT,
    MODE_DUAL_IN,
    MODE_QUAD_IN,
    MODE_DUAL_OUT,
    MODE_QUAD_OUT
  } lane_mode_t;
  // link state
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_PAUSED} link_state_t;
  // one byte with its strobe
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_word_t;
endpackage

// *** core/flash_pin_logic.sv ***
// pin-level serial lane logic of a quad-lane serial flash
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_consts.svh"

// ==========================================================
// two-entry buffer, flip-flop storage addressed by index
module byte_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk, // core clock
  input wire logic rstn, // async reset, low
  input wire logic in_valid, // write strobe
  output logic in_ready, // room left
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // word held
  input wire logic out_ready, // reader takes
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage written only on push, so no reset is needed on the data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // pointers wrap at depth
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_buf

// ==========================================================
module flash_pin_logic (
  input wire logic clk, // 40 MHz core clock
  input wire logic rstn, // async reset, low
  input wire logic sck, // serial clock pin
  input wire logic cs_n, // select pin, low active
  input wire logic data_lane_zero_in, // lane zero pin level
  output logic data_lane_zero_out, // lane zero drive value
  output logic data_lane_zero_oe, // lane zero drive enable
  input wire logic data_lane_one_in, // lane one pin level
  output logic data_lane_one_out, // lane one drive value
  output logic data_lane_one_oe, // lane one drive enable
  input wire logic data_lane_two_in, // lane two / write-protect pin
  output logic data_lane_two_out, // lane two drive value
  output logic data_lane_two_oe, // lane two drive enable
  input wire logic data_lane_three_in, // lane three / pause pin
  output logic data_lane_three_out, // lane three drive value
  output logic data_lane_three_oe, // lane three drive enable
  input wire flash_pin_pkg::lane_mode_t lane_mode, // current phase, from core
  input wire logic quad_lanes_enable, // configuration bit
  input wire logic busy_internal, // self-timed cycle running
  input wire flash_pin_pkg::byte_word_t tx_word, // byte to send
  output logic tx_ready, // buffer has room
  output flash_pin_pkg::byte_word_t rx_word, // received byte, pulse
  output logic frame_start, // select fell, pulse
  output logic frame_end, // select rose, pulse
  output logic write_protect_n, // locking control, low locks
  output logic standby // idle and not busy
);
  // ==========================================================
  // pin synchronisers: {lane3, lane2, lane1, lane0, cs_n, sck}
  logic [5:0] s1_q, s2_q;
  logic sck_prev_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= `FP_SYNC_RST;
      s2_q <= `FP_SYNC_RST;
    end else begin
      s1_q <= {data_lane_three_in, data_lane_two_in, data_lane_one_in, data_lane_zero_in, cs_n, sck};
      s2_q <= s1_q;
    end
  end
  logic sck_s, sel, pause_req;
  logic [3:0] lanes_s;
  assign sck_s = s2_q[0];
  assign sel = ~s2_q[1];
  assign lanes_s = s2_q[5:2];
  // pause pin is a control only without quad enable
  assign pause_req = !quad_lanes_enable && !lanes_s[3];

  // ==========================================================
  // effective mode: quad phases fall back when upper lanes are controls
  flash_pin_pkg::lane_mode_t mode;
  always_comb begin
    mode = lane_mode;
    if (!quad_lanes_enable && (lane_mode == flash_pin_pkg::MODE_QUAD_IN)) begin
      mode = flash_pin_pkg::MODE_SINGLE_IN;
    end
    if (!quad_lanes_enable && (lane_mode == flash_pin_pkg::MODE_QUAD_OUT)) begin
      mode = flash_pin_pkg::MODE_SINGLE_OUT;
    end
  end
  logic [3:0] width, oe_mode;
  logic out_phase;
  always_comb begin
    unique case (mode)
      flash_pin_pkg::MODE_DUAL_IN, flash_pin_pkg::MODE_DUAL_OUT: width = `FP_W_DUAL;
      flash_pin_pkg::MODE_QUAD_IN, flash_pin_pkg::MODE_QUAD_OUT: width = `FP_W_QUAD;
      default: width = `FP_W_SINGLE;
    endcase
    unique case (mode)
      flash_pin_pkg::MODE_SINGLE_OUT: oe_mode = `FP_OE_SINGLE;
      flash_pin_pkg::MODE_DUAL_OUT: oe_mode = `FP_OE_DUAL;
      flash_pin_pkg::MODE_QUAD_OUT: oe_mode = `FP_OE_QUAD;
      default: oe_mode = `FP_LANES_OFF;
    endcase
  end
  assign out_phase = (oe_mode != `FP_LANES_OFF);

  // ==========================================================
  // link state: frames and pause
  flash_pin_pkg::link_state_t state_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= flash_pin_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        flash_pin_pkg::ST_IDLE: if (sel) state_q <= flash_pin_pkg::ST_ACTIVE;
        flash_pin_pkg::ST_ACTIVE: begin
          if (!sel) begin
            state_q <= flash_pin_pkg::ST_IDLE;
          end else if (pause_req && !sck_s) begin
            state_q <= flash_pin_pkg::ST_PAUSED;
          end
        end
        // pause does not deselect; counters are left as they stand
        flash_pin_pkg::ST_PAUSED: begin
          if (!sel) begin
            state_q <= flash_pin_pkg::ST_IDLE;
          end else if (!pause_req) begin
            state_q <= flash_pin_pkg::ST_ACTIVE;
          end
        end
      endcase
    end
  end
  logic active, rise, fall;
  assign active = (state_q == flash_pin_pkg::ST_ACTIVE) && sel;
  // prev tracks through pause, so release never fakes an edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end
  assign rise = active && sck_s && !sck_prev_q;
  assign fall = active && !sck_s && sck_prev_q;
  assign frame_start = (state_q == flash_pin_pkg::ST_IDLE) && sel;
  assign frame_end = (state_q != flash_pin_pkg::ST_IDLE) && !sel;
  // busy is passed through untouched by pause
  assign standby = (state_q == flash_pin_pkg::ST_IDLE) && !busy_internal;

  // ==========================================================
  // receive shifter, msb first
  logic [7:0] rx_sh_q, rx_next;
  logic [3:0] rx_cnt_q, rx_cnt_n;
  always_comb begin
    unique case (width)
      `FP_W_DUAL: rx_next = {rx_sh_q[5:0], lanes_s[1:0]};
      `FP_W_QUAD: rx_next = {rx_sh_q[3:0], lanes_s[3:0]};
      default: rx_next = {rx_sh_q[6:0], lanes_s[0]};
    endcase
  end
  assign rx_cnt_n = rx_cnt_q + width;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sh_q <= `FP_BYTE_RST;
      rx_cnt_q <= `FP_CNT_RST;
      rx_word <= '0;
    end else begin
      rx_word.valid <= 1'b0;
      if (frame_start) begin
        rx_cnt_q <= `FP_CNT_RST;
      end else if (rise) begin
        rx_sh_q <= rx_next;
        rx_cnt_q <= (rx_cnt_n == `FP_BYTE_BITS) ? `FP_CNT_RST : rx_cnt_n;
        if (rx_cnt_n == `FP_BYTE_BITS) begin
          rx_word.valid <= 1'b1;
          rx_word.data <= rx_next;
        end
      end
    end
  end

  // ==========================================================
  // transmit path: buffer keeps bytes while the shifter is busy
  logic buf_valid, buf_pop;
  logic [7:0] buf_data;
  logic [7:0] tx_sh_q, tx_src;
  logic [3:0] tx_cnt_q, dout_q;
  byte_buf #(.WIDTH(8), .DEPTH(2)) u_tx_buf (
    .clk(clk),
    .rstn(rstn),
    .in_valid(tx_word.valid),
    .in_ready(tx_ready),
    .in_data(tx_word.data),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_data)
  );
  assign buf_pop = fall && out_phase && (tx_cnt_q == `FP_CNT_RST);
  assign tx_src = (tx_cnt_q == `FP_CNT_RST) ? buf_data : tx_sh_q;
  // underrun holds the lanes at their last value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh_q <= `FP_BYTE_RST;
      tx_cnt_q <= `FP_CNT_RST;
      dout_q <= `FP_LANES_OFF;
    end else if (frame_start) begin
      tx_cnt_q <= `FP_CNT_RST;
    end else if (fall && out_phase && (buf_valid || (tx_cnt_q != `FP_CNT_RST))) begin
      unique case (width)
        `FP_W_DUAL: begin
          dout_q <= {2'h0, tx_src[7:6]};
          tx_sh_q <= {tx_src[5:0], 2'h0};
        end
        `FP_W_QUAD: begin
          dout_q <= tx_src[7:4];
          tx_sh_q <= {tx_src[3:0], 4'h0};
        end
        default: begin
          dout_q <= {2'h0, tx_src[7], 1'b0};
          tx_sh_q <= {tx_src[6:0], 1'b0};
        end
      endcase
      tx_cnt_q <= ((tx_cnt_q == `FP_CNT_RST) ? `FP_BYTE_BITS : tx_cnt_q) - width;
    end
  end
  // drive only while selected, running and in an output phase
  logic [3:0] oe;
  assign oe = (active && out_phase) ? oe_mode : `FP_LANES_OFF;
  assign {data_lane_three_oe, data_lane_two_oe, data_lane_one_oe, data_lane_zero_oe} = oe;
  assign {data_lane_three_out, data_lane_two_out, data_lane_one_out, data_lane_zero_out} = dout_q;

  // ==========================================================
  // write-protect level held while lane two carries data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_protect_n <= `FP_WP_RST;
    end else if (!quad_lanes_enable) begin
      write_protect_n <= lanes_s[2];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_rx_on_rise: assert property (rx_word.valid |-> $past(rise)) else $error("byte without rise");
  chk_tx_on_fall: assert property ($changed(dout_q) |-> $past(fall)) else $error("lane change off fall");
  chk_prog_no_drive: assert property ((mode == flash_pin_pkg::MODE_DUAL_IN || mode == flash_pin_pkg::MODE_QUAD_IN)
    |-> oe == `FP_LANES_OFF) else $error("lane driven in program");
  chk_dual_read_oe: assert property ((active && mode == flash_pin_pkg::MODE_DUAL_OUT) |-> oe == `FP_OE_DUAL)
    else $error("dual read lanes");
  chk_desel_ignore: assert property ((!sel && !$past(sel)) |-> !rx_word.valid && !rise) else $error("deselected input");
  chk_desel_float: assert property (!sel |-> oe == `FP_LANES_OFF) else $error("lane driven deselected");
  chk_qe_upper: assert property (!quad_lanes_enable |-> !oe[2] && !oe[3]) else $error("upper lane driven");
  chk_pause_freeze: assert property ((state_q == flash_pin_pkg::ST_PAUSED) [*2] |-> $stable(rx_cnt_q) && $stable(tx_cnt_q)
    && oe == `FP_LANES_OFF) else $error("pause moved shifter");
  chk_pause_entry: assert property ($rose(state_q == flash_pin_pkg::ST_PAUSED) |-> !$past(sck_s) && $past(sel))
    else $error("pause with clock high");
  chk_standby_busy: assert property (standby |-> !busy_internal && !$past(sel)) else $error("standby while busy");
  cov_quad_read: cover property (fall && mode == flash_pin_pkg::MODE_QUAD_OUT && buf_pop);
  cov_quad_prog: cover property (rx_word.valid && mode == flash_pin_pkg::MODE_QUAD_IN);
  cov_pause: cover property ($fell(state_q == flash_pin_pkg::ST_PAUSED) && sel);
endmodule // flash_pin_logic
`default_nettype wire

// *** sim/spi_host_model.sv ***
// host controller model driving select, serial clock and lanes of the flash pin logic
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk, // core clock, paces the pins
  output logic sck, // serial clock pin
  output logic cs_n, // select pin, low active
  output logic [3:0] lane_in, // resolved lane levels
  input wire logic [3:0] dev_out, // device drive values
  input wire logic [3:0] dev_oe // device drive enables
);
  logic [3:0] h_val = 4'h0;
  logic [3:0] h_en = 4'h0;
  logic junk_q = 1'b0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  // ==========================================================
  // wire levels: upper lanes pulled high, lower lanes toggle when nobody drives
  always @(negedge clk) junk_q <= ~junk_q;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = dev_oe[i] ? dev_out[i] : h_en[i] ? h_val[i] : (i > 1) ? 1'b1 : junk_q;
    end
  end
  // ==========================================================
  // select moves only while sck is low
  task automatic sel(input logic on);
    @(negedge clk);
    cs_n = ~on;
    repeat (4) @(negedge clk);
  endtask
  // one serial period: drive in the low phase, sample at the rise
  task automatic edge_io(input logic [3:0] d, input logic [3:0] en, output logic [3:0] q);
    @(negedge clk);
    h_val = d;
    h_en = en;
    repeat (3) @(negedge clk);
    sck = 1'b1;
    q = lane_in;
    repeat (4) @(negedge clk);
    sck = 1'b0;
  endtask
  // static lane levels, pause only entered with sck low
  task automatic pin(input logic [3:0] en, input logic [3:0] d);
    @(negedge clk);
    h_en = en;
    h_val = d;
    repeat (6) @(negedge clk);
  endtask
endmodule // spi_host_model
`default_nettype wire

// *** sim/flash_pin_logic_tb.sv ***
// self-checking bench of the flash pin logic
`timescale 1ns/1ps
`default_nettype none
module flash_pin_logic_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sck, cs_n, tx_ready, frame_start, frame_end, wp_n, standby;
  logic [3:0] lane_in, dout, oe, hq;
  flash_pin_pkg::lane_mode_t lane_mode = flash_pin_pkg::MODE_SINGLE_IN;
  logic qe = 1'b1;
  logic busy = 1'b0;
  flash_pin_pkg::byte_word_t tx_word = '0;
  flash_pin_pkg::byte_word_t rx_word;
  int failures = 0;
  int cmp_count = 0;
  int nfs = 0;
  int nfe = 0;
  logic [31:0] seed = 32'hebc53e21;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  always #12.5 clk = ~clk;
  flash_pin_logic flash_pin_logic_i (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n),
    .data_lane_zero_in(lane_in[0]), .data_lane_zero_out(dout[0]), .data_lane_zero_oe(oe[0]),
    .data_lane_one_in(lane_in[1]), .data_lane_one_out(dout[1]), .data_lane_one_oe(oe[1]),
    .data_lane_two_in(lane_in[2]), .data_lane_two_out(dout[2]), .data_lane_two_oe(oe[2]),
    .data_lane_three_in(lane_in[3]), .data_lane_three_out(dout[3]), .data_lane_three_oe(oe[3]),
    .lane_mode(lane_mode), .quad_lanes_enable(qe), .busy_internal(busy), .tx_word(tx_word),
    .tx_ready(tx_ready), .rx_word(rx_word), .frame_start(frame_start), .frame_end(frame_end),
    .write_protect_n(wp_n), .standby(standby));
  spi_host_model spi_host_model_i (.clk(clk), .sck(sck), .cs_n(cs_n), .lane_in(lane_in),
    .dev_out(dout), .dev_oe(oe));
  // ==========================================================
  // monitor: received bytes and frame pulses, sampled mid-cycle where outputs are settled
  always @(negedge clk) begin
    if (rx_word.valid === 1'b1) rxq.push_back(rx_word.data);
    if (frame_start === 1'b1) nfs++;
    if (frame_end === 1'b1) nfe++;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // write one byte through the input lanes, msb first
  task automatic wr(input int w, input logic [7:0] d);
    logic [3:0] en;
    en = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
    spi_host_model_i.sel(1'b1);
    for (int i = 0; i < 8 / w; i++) begin
      spi_host_model_i.edge_io(4'((d >> (8 - w * (i + 1))) & ((1 << w) - 1)), en, hq);
      check("lane one drive", {7'h0, oe[1]}, 8'h0);
    end
    spi_host_model_i.sel(1'b0);
    for (int i = 0; i < 40 && rxq.size() == 0; i++) @(negedge clk);
    check("rx count", 8'(rxq.size()), 8'h1);
    if (rxq.size() != 0) check("rx byte", rxq.pop_front(), d);
  endtask
  // read two buffered bytes in one frame, optionally pausing mid byte
  task automatic rd(input int w, input logic hold);
    logic [7:0] acc;
    spi_host_model_i.sel(1'b1);
    spi_host_model_i.edge_io(4'h0, 4'h0, hq); // first fall launches the top bits
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 8 / w; i++) begin
        if (hold && b == 0 && i == 4) begin
          spi_host_model_i.pin(4'h8, 4'h0);
          check("paused drive", {4'h0, oe}, 8'h0);
          spi_host_model_i.edge_io(4'h0, 4'h8, hq);
          spi_host_model_i.pin(4'h0, 4'h0);
        end
        spi_host_model_i.edge_io(4'h0, 4'h0, hq);
        if (w == 4) check("quad drive", {4'h0, oe}, 8'h0f);
        acc = (acc << w) | ((w == 1) ? 8'(hq[1]) : (w == 2) ? 8'(hq[1:0]) : 8'(hq));
      end
      check("read byte", acc, txq.pop_front());
    end
    spi_host_model_i.sel(1'b0);
    check("released drive", {4'h0, oe}, 8'h0);
  endtask
  task automatic push(input logic [7:0] d, input logic keep);
    @(negedge clk);
    tx_word = '{valid: 1'b1, data: d};
    @(negedge clk);
    tx_word.valid = 1'b0;
    if (keep) txq.push_back(d);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    check("reset drive", {4'h0, oe}, 8'h0);
    check("reset ready", {7'h0, tx_ready}, 8'h1);
    qe = 1'b0;
    spi_host_model_i.pin(4'h0, 4'h0);
    check("lock released", {7'h0, wp_n}, 8'h1);
    spi_host_model_i.pin(4'h4, 4'h0);
    check("lock set", {7'h0, wp_n}, 8'h0);
    spi_host_model_i.pin(4'h0, 4'h0);
    for (int i = 0; i < 4; i++) spi_host_model_i.edge_io(4'h1, 4'h1, hq);
    check("deselected rx", 8'(rxq.size()), 8'h0);
    check("deselected frames", 8'(nfs), 8'h0);
    check("deselected ends", 8'(nfe), 8'h0);
    $display("pin control test done");
    // input phases; quad with lanes disabled must behave as single
    for (int m = 0; m < 4; m++) begin
      qe = (m != 3);
      lane_mode = (m == 0) ? flash_pin_pkg::MODE_SINGLE_IN : (m == 1) ? flash_pin_pkg::MODE_DUAL_IN
        : flash_pin_pkg::MODE_QUAD_IN;
      wr((m == 1) ? 2 : (m == 2) ? 4 : 1, 8'ha5);
      wr((m == 1) ? 2 : (m == 2) ? 4 : 1, rnd());
      check("frame starts", 8'(nfs), 8'(2 * m + 2));
      check("frame ends", 8'(nfe), 8'(2 * m + 2));
      $display("write mode %0d test done", m);
    end
    // busy internal cycle keeps standby off, transfers go on
    busy = 1'b1;
    wr(1, rnd());
    check("standby busy", {7'h0, standby}, 8'h0);
    busy = 1'b0;
    @(negedge clk);
    check("standby idle", {7'h0, standby}, 8'h1);
    $display("standby test done");
    // output phases, buffer filled and overfilled, last one paused
    for (int m = 0; m < 4; m++) begin
      qe = (m != 3);
      lane_mode = (m == 1) ? flash_pin_pkg::MODE_DUAL_OUT : (m == 2) ? flash_pin_pkg::MODE_QUAD_OUT
        : flash_pin_pkg::MODE_SINGLE_OUT;
      push((m == 0) ? 8'h81 : rnd(), 1'b1);
      push(rnd(), 1'b1);
      check("buffer full", {7'h0, tx_ready}, 8'h0);
      push(8'hff, 1'b0);
      rd((m == 1) ? 2 : (m == 2) ? 4 : 1, m == 3);
      $display("read mode %0d test done", m);
    end
    results();
  end
  initial begin
    #2ms;
    failures++;
    results();
  end
endmodule // flash_pin_logic_tb
`default_nettype wire
